// ===== src/cal_mode_change_sequencer.sv
// Mode-change sequencer: measuring unit modes and output board follower.
//
// Behaviour
// - Normal request enters normal_settling at next boundary.
// - Broadcast unit mode on every mode entry.
// - normal_settling lasts average count, then normal.
// - Board mode comes only from unit mode.
// - Board mode trails unit by one period.
// - Board follows settling then normal, with relays.
// - Analog outputs slew toward normal data.
// - normal_settling data flagged not valid.
// - Upper request starts upper_cal_settling, one average.
// - Upper phase lasts upper minus average, holds.
// - Lower request: settling, then lower minus average.
// - Zero request: settling, then zero minus average.
// - Board enters settling after one full period.
// - Board settles until first steady period ends.
// - Cal-enabled outputs refresh with every reading.
// - Other outputs freeze at last normal reading.
// - Relays updated on every board mode change.
// - Averaging period is average count times period.
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cal_seq_defs.svh"

module cal_mode_change_sequencer
    import cal_seq_pkg::*;
#(
    parameter int NCH = 4,
    parameter int DW  = 16,
    parameter int CW  = 8
)(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [7:0]          address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    output logic      [31:0]         readdata,
    output logic                     waitrequest,
    input  wire logic                period_tick,
    input  wire req_t                ext_req,
    input  wire logic [NCH*DW-1:0]   reading,
    output mode_t                    unit_mode,
    output logic                     mode_bcast,
    output mode_t                    board_mode,
    output logic [7:0]               relay,
    output logic [NCH*DW-1:0]        aout,
    output logic                     emis_valid
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (NCH < 1 || NCH > 8 || DW < 2 || DW > 32 || CW < 2 || CW > 8)
    begin : g_bad_param
        $error("cal_mode_change_sequencer: unsupported parameter set");
    end

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // A steady mode request maps to its settling mode.
    function automatic mode_t settle_of(input mode_t m);
        case (m)
            M_UP:    settle_of = M_UP_SET;
            M_LO:    settle_of = M_LO_SET;
            M_ZR:    settle_of = M_ZR_SET;
            default: settle_of = M_NORM_SET;
        endcase
    endfunction : settle_of

    // True for any calibration mode, settling or steady.
    function automatic logic is_cal(input mode_t m);
        is_cal = (m != M_NORM) && (m != M_NORM_SET);
    endfunction : is_cal

    // One relay per mode; bit index is the mode code.
    function automatic logic [7:0] relay_of(input mode_t m);
        relay_of = 8'h01 << m;
    endfunction : relay_of

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    mode_t            unit_q;
    mode_t            board_q;
    mode_t            pend_mode_q;
    logic             pend_q;
    logic [CW-1:0]    cnt_q;
    logic             done_q;
    logic             bcast_q;
    logic [7:0]       relay_q;
    logic             valid_q;
    logic             wait_q;
    logic [31:0]      rdata_q;
    logic [CW-1:0]    avg_q;
    logic [CW-1:0]    upper_q;
    logic [CW-1:0]    lower_q;
    logic [CW-1:0]    zero_q;
    logic [7:0]       cal_en_q;
    logic [DW-1:0]    aout_q [NCH];

    // ------------------------------------------------------------------
    // Avalon-MM slave decode
    // ------------------------------------------------------------------
    // One wait state: the access completes on the edge after waitrequest
    // drops, which keeps readdata and waitrequest straight from flops.
    wire rd_take  = read && wait_q;
    wire wr_ack   = write && !wait_q;
    wire sel_ctrl = (address == `CS_OFS_CTRL);
    wire sel_avg  = (address == `CS_OFS_AVG);
    wire sel_up   = (address == `CS_OFS_UPPER);
    wire sel_lo   = (address == `CS_OFS_LOWER);
    wire sel_zr   = (address == `CS_OFS_ZERO);
    wire sel_cen  = (address == `CS_OFS_CAL_EN);
    wire sel_st   = (address == `CS_OFS_STATUS);

    wire [31:0] status_w = {21'h0, valid_q, done_q, pend_q, 1'b0,
                            board_q, 1'b0, unit_q};
    wire [31:0] cfg_w    = {24'h0000_00, 8'(cal_en_q)};
    wire [31:0] rd_w     = sel_avg ? 32'(avg_q)   :
                           sel_up  ? 32'(upper_q) :
                           sel_lo  ? 32'(lower_q) :
                           sel_zr  ? 32'(zero_q)  :
                           sel_cen ? cfg_w        :
                           sel_st  ? status_w     : 32'h0000_0000;

    // Software request from the control register; a pin request in the
    // same cycle takes precedence since it is the newer physical event.
    wire   sw_req  = wr_ack && sel_ctrl && writedata[`CS_CTRL_GO_BIT];
    wire   new_req = ext_req.valid || sw_req;
    mode_t new_mode;
    assign new_mode = ext_req.valid ? ext_req.mode : mode_t'(writedata[2:0]);

    // Bus handshake and read data.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wait_q  <= !((read || write) && wait_q);
            // Loaded when the read is taken, so the data already stand
            // at the edge where the master sees waitrequest low.
            rdata_q <= rd_take ? rd_w : 32'h0000_0000;
        end
    end

    // Configuration registers.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            avg_q    <= CW'(`CS_AVG_RST);
            upper_q  <= CW'(`CS_CAL_LEN_RST);
            lower_q  <= CW'(`CS_CAL_LEN_RST);
            zero_q   <= CW'(`CS_CAL_LEN_RST);
            cal_en_q <= `CS_CAL_EN_RST;
        end
        else if (wr_ack)
        begin
            if (sel_avg)      avg_q    <= writedata[CW-1:0];
            else if (sel_up)  upper_q  <= writedata[CW-1:0];
            else if (sel_lo)  lower_q  <= writedata[CW-1:0];
            else if (sel_zr)  zero_q   <= writedata[CW-1:0];
            else if (sel_cen) cal_en_q <= writedata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Measuring unit sequencer
    // ------------------------------------------------------------------
    // Steady length is the calibration count less the settling count,
    // floored at zero so a short setting never wraps the counter.
    wire [CW-1:0] cal_len = (unit_q == M_UP) ? upper_q :
                            (unit_q == M_LO) ? lower_q : zero_q;
    wire [CW-1:0] steady_len = (cal_len > avg_q) ? cal_len - avg_q : '0;
    wire [CW-1:0] cnt_inc    = cnt_q + CW'(1);
    wire          settling   = unit_q[0] ^ unit_q[1] ^ unit_q[2] ^ 1'b1;
    wire          settle_end = cnt_inc >= avg_q;

    // Pending request: the set wins over the boundary that consumes it.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_q      <= 1'b0;
            pend_mode_q <= M_NORM;
        end
        else if (new_req)
        begin
            pend_q      <= 1'b1;
            pend_mode_q <= new_mode;
        end
        else if (period_tick)
        begin
            pend_q      <= 1'b0;
        end
    end

    // Mode moves only on an integration-period boundary.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            unit_q <= M_NORM;
            cnt_q  <= '0;
            done_q <= 1'b0;
        end
        else if (period_tick)
        begin
            if (pend_q)
            begin
                unit_q <= settle_of(pend_mode_q);
                cnt_q  <= '0;
                done_q <= 1'b0;
            end
            else if (settling && settle_end)
            begin
                unit_q <= mode_t'(unit_q ^ 3'b001);
                cnt_q  <= '0;
                done_q <= 1'b0;
            end
            else if (settling)
            begin
                cnt_q  <= cnt_inc;
            end
            else if (unit_q != M_NORM && cnt_q < steady_len)
            begin
                cnt_q  <= cnt_inc;
                done_q <= (cnt_inc >= steady_len);
            end
            // Normal and finished steady modes hold here.
        end
    end

    // ------------------------------------------------------------------
    // Output board follower
    // ------------------------------------------------------------------
    // Results for a period arrive at its closing boundary, so the board
    // adopts the mode the unit held through that period.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            board_q <= M_NORM;
            relay_q <= 8'h02;
            valid_q <= 1'b1;
            bcast_q <= 1'b0;
        end
        else
        begin
            bcast_q <= period_tick && (pend_q || (settling && settle_end));
            if (period_tick)
            begin
                board_q <= unit_q;
                relay_q <= relay_of(unit_q);
                valid_q <= (unit_q == M_NORM);
            end
        end
    end

    // Analog channels: cal-enabled ones track readings, the others
    // freeze; in normal modes every channel slews toward its reading.
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
        wire [DW-1:0] rd   = reading[c*DW +: DW];
        wire [DW-1:0] cur  = aout_q[c];
        wire [DW-1:0] step = DW'(`CS_SLEW_STEP);
        wire [DW-1:0] up_v = (rd - cur > step) ? cur + step : rd;
        wire [DW-1:0] dn_v = (cur - rd > step) ? cur - step : rd;
        wire [DW-1:0] slew = (rd >= cur) ? up_v : dn_v;

        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
                aout_q[c] <= '0;
            else if (period_tick && !is_cal(unit_q))
                aout_q[c] <= slew;
            else if (period_tick && cal_en_q[c])
                aout_q[c] <= rd;
            // Channels without cal keep the last normal value.
        end

        assign aout[c*DW +: DW] = aout_q[c];
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign readdata    = rdata_q;
    assign waitrequest = wait_q;
    assign unit_mode   = unit_q;
    assign mode_bcast  = bcast_q;
    assign board_mode  = board_q;
    assign relay       = relay_q;
    assign emis_valid  = valid_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_UNIT_ON_TICK: assert property (@(posedge clk) disable iff (!rst_b)
        (unit_q != $past(unit_q)) |-> $past(period_tick))
        else $error("Unit mode changed off a period boundary.");

    AST_NORM_ENTRY: assert property (@(posedge clk) disable iff (!rst_b)
        (period_tick && pend_q && pend_mode_q == M_NORM)
        |=> unit_q == M_NORM_SET)
        else $error("Normal request did not enter normal settling.");

    AST_CAL_ENTRY: assert property (@(posedge clk) disable iff (!rst_b)
        (period_tick && pend_q && pend_mode_q == M_UP)
        |=> unit_q == M_UP_SET)
        else $error("Upper request did not enter upper settling.");

    AST_BCAST: assert property (@(posedge clk) disable iff (!rst_b)
        (period_tick && pend_q) |=> mode_bcast)
        else $error("Mode entry was not broadcast.");

    AST_BOARD_LAG: assert property (@(posedge clk) disable iff (!rst_b)
        period_tick |=> board_q == $past(unit_q))
        else $error("Board mode does not trail unit by one period.");

    AST_SETTLE_LEN: assert property (@(posedge clk) disable iff (!rst_b)
        (period_tick && !pend_q && settling && cnt_inc < avg_q)
        |=> unit_q == $past(unit_q))
        else $error("Settling left before the average count.");

    AST_NORM_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        (unit_q == M_NORM && !pend_q && !new_req) |=> unit_q == M_NORM)
        else $error("Normal mode left without a request.");

    AST_RELAY: assert property (@(posedge clk) disable iff (!rst_b)
        (board_q != $past(board_q)) |-> relay_q != $past(relay_q))
        else $error("Relays not updated on board mode change.");

    AST_INVALID: assert property (@(posedge clk) disable iff (!rst_b)
        (board_q == M_NORM_SET) |-> !emis_valid)
        else $error("Settling data flagged valid.");

    AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_b)
        (period_tick && is_cal(unit_q) && !cal_en_q[NCH-1])
        |=> $stable(aout_q[NCH-1]))
        else $error("Output without cal moved during calibration.");

    AST_BUS_ONE: assert property (@(posedge clk) disable iff (!rst_b)
        !wait_q |=> wait_q)
        else $error("Waitrequest low for more than one cycle.");

endmodule : cal_mode_change_sequencer
`default_nettype wire

// ===== src/cal_seq_defs.svh
// Register offsets, field positions, reset values and counts for the sequencer.
`ifndef CAL_SEQ_DEFS_SVH
`define CAL_SEQ_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CS_OFS_CTRL      8'h00
`define CS_OFS_AVG       8'h04
`define CS_OFS_UPPER     8'h08
`define CS_OFS_LOWER     8'h0C
`define CS_OFS_ZERO      8'h10
`define CS_OFS_CAL_EN    8'h14
`define CS_OFS_STATUS    8'h18

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CS_CTRL_GO_BIT   3
`define CS_ST_BOARD_LSB  4
`define CS_ST_PEND_BIT   8
`define CS_ST_DONE_BIT   9
`define CS_ST_VALID_BIT  10
`define CS_AVG_RST       8'h06
`define CS_CAL_LEN_RST   8'h0C
`define CS_CAL_EN_RST    8'h00
`define CS_SLEW_STEP     16'h0010

`endif

// ===== src/cal_seq_pkg.sv
// Types shared by the mode-change sequencer and its users.
package cal_seq_pkg;

    // Mode codes, Gray coded along normal and calibration paths.
    typedef enum logic [2:0] {
        M_NORM_SET = 3'b000,
        M_NORM     = 3'b001,
        M_ZR_SET   = 3'b011,
        M_ZR       = 3'b010,
        M_LO_SET   = 3'b110,
        M_LO       = 3'b111,
        M_UP_SET   = 3'b101,
        M_UP       = 3'b100
    } mode_t;

    // Mode-change request from panel, keypad, inputs or scheduler.
    typedef struct packed {
        logic  valid;
        mode_t mode;
    } req_t;

endpackage : cal_seq_pkg

// ===== sim/mode_req_source.sv
// Request source model: period boundaries and mode-change requests.
`timescale 1ns/100ps
`default_nettype none

module mode_req_source
    import cal_seq_pkg::*;
(
    input  wire logic clk,
    output var logic  period_tick,
    output var req_t  ext_req
);
    // Idle from time zero, so reset never sees a stray request.
    initial
    begin
        period_tick = 1'b0;
        ext_req     = '0;
    end

    // One-cycle boundary pulse; returns at the edge that samples it.
    task automatic tick();
        @(posedge clk) period_tick <= 1'b1;
        @(posedge clk) period_tick <= 1'b0;
    endtask : tick

    // One-cycle request pulse, as the panel and inputs deliver it.
    task automatic send(input mode_t m);
        @(posedge clk) ext_req <= '{valid: 1'b1, mode: m};
        @(posedge clk) ext_req.valid <= 1'b0;
    endtask : send
endmodule : mode_req_source

`default_nettype wire

// ===== sim/cal_mode_change_sequencer_tb_top.sv
// Self-checking bench for the mode-change sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "cal_seq_defs.svh"

module cal_mode_change_sequencer_tb_top
    import cal_seq_pkg::*;
;
    logic        clk, rst_b, read, write, period_tick, waitrequest;
    logic        mode_bcast, emis_valid, pend, chg;
    logic [7:0]  address, relay;
    logic [31:0] writedata, readdata, q;
    logic [63:0] reading, aout;
    req_t        ext_req;
    mode_t       unit_mode, board_mode, eu, eb, pmode;
    int          error_cnt = 0, checks = 0, cnt = 0, avg = 6;
    logic [7:0]  ofs [6] = '{`CS_OFS_AVG, `CS_OFS_UPPER, `CS_OFS_LOWER,
                             `CS_OFS_ZERO, `CS_OFS_CAL_EN, 8'h1C};
    logic [31:0] rv [6]  = '{32'h0000_0006, 32'h0000_000C, 32'h0000_000C,
                             32'h0000_000C, 32'h0000_0000, 32'h0000_0000};

    // Free-running 200 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    cal_mode_change_sequencer uut (
        .clk(clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .period_tick(period_tick),
        .ext_req(ext_req), .reading(reading), .unit_mode(unit_mode),
        .mode_bcast(mode_bcast), .board_mode(board_mode), .relay(relay),
        .aout(aout), .emis_valid(emis_valid)
    );

    mode_req_source pm (
        .clk(clk), .period_tick(period_tick), .ext_req(ext_req)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        checks = checks + 1;
        if (s !== e)
        begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk

    task automatic results();
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // Avalon access held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        address   <= a;
        writedata <= d;
        write     <= w;
        read      <= ~w;
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask : bus

    function automatic mode_t set_of(input mode_t m);
        case (m)
            M_UP:    return M_UP_SET;
            M_LO:    return M_LO_SET;
            M_ZR:    return M_ZR_SET;
            default: return M_NORM_SET;
        endcase
    endfunction : set_of

    function automatic mode_t steady_of(input mode_t m);
        case (m)
            M_UP_SET: return M_UP;
            M_LO_SET: return M_LO;
            M_ZR_SET: return M_ZR;
            default:  return M_NORM;
        endcase
    endfunction : steady_of

    // A request settles two spare cycles before any boundary follows.
    task automatic req(input logic sw, input mode_t m);
        if (sw)
            bus(1'b1, `CS_OFS_CTRL, 32'h0000_0008 | m);
        else
            pm.send(m);
        pend  = 1'b1;
        pmode = m;
        repeat (2) @(posedge clk);
    endtask : req

    // One boundary; the expected modes advance by their own count.
    task automatic step(input int gap);
        chg = 1'b0;
        eb  = eu;
        if (pend)
        begin
            eu   = set_of(pmode);
            pend = 1'b0;
            cnt  = 0;
            chg  = 1'b1;
        end
        else if (eu inside {M_NORM_SET, M_ZR_SET, M_LO_SET, M_UP_SET})
        begin
            cnt = cnt + 1;
            if (cnt == avg)
            begin
                eu  = steady_of(eu);
                chg = 1'b1;
            end
        end
        pm.tick();
        #1;
        chk(mode_bcast, chg);
        chk(unit_mode, eu);
        @(posedge clk);
        #1;
        chk(board_mode, eb);
        chk(relay, 8'h01 << eb);
        chk(emis_valid, eb == M_NORM);
        repeat (gap) @(posedge clk);
    endtask : step

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst_b     = 1'b0;
        read      = 1'b0;
        write     = 1'b0;
        address   = 8'h00;
        writedata = 32'h0000_0000;
        reading   = {4{16'h0030}};
        eu        = M_NORM;
        pmode     = M_NORM;
        pend      = 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ofs[i])
        begin
            bus(1'b0, ofs[i], 32'h0000_0000);
            chk(q, rv[i]);
        end
        bus(1'b0, `CS_OFS_STATUS, 32'h0000_0000);
        chk(q & 32'h0000_0577, 32'h0000_0411);
        // Outputs slew up from zero in fixed steps while normal.
        for (int i = 1; i <= 4; i++)
        begin
            step(2);
            chk(aout[15:0], 16 * ((i < 3) ? i : 3));
        end
        chk(aout, {4{16'h0030}});
        bus(1'b1, `CS_OFS_AVG, 32'h0000_0002);
        avg = 2;
        bus(1'b1, `CS_OFS_UPPER, 32'h0000_0005);
        bus(1'b1, `CS_OFS_CAL_EN, 32'h0000_0001);
        bus(1'b0, `CS_OFS_AVG, 32'h0000_0000);
        chk(q, 32'h0000_0002);
        // Upper point: settling, steady count of three, then holding.
        req(1'b0, M_UP);
        bus(1'b0, `CS_OFS_STATUS, 32'h0000_0000);
        chk(q[`CS_ST_PEND_BIT], 1'b1);
        step(0);
        step(6);
        @(posedge clk) reading <= {4{16'h0555}};
        step(2);
        bus(1'b0, `CS_OFS_STATUS, 32'h0000_0000);
        chk(q[`CS_ST_DONE_BIT], 1'b0);
        repeat (4) step(2);
        bus(1'b0, `CS_OFS_STATUS, 32'h0000_0000);
        chk(q[`CS_ST_DONE_BIT], 1'b1);
        chk(aout, {{3{16'h0030}}, 16'h0555});
        // A register request replaces a pending pin request.
        req(1'b0, M_UP);
        req(1'b1, M_LO);
        repeat (4) step(1);
        req(1'b0, M_ZR);
        repeat (4) step(3);
        req(1'b0, M_NORM);
        step(2);
        // Back in normal modes the cal channel walks down in fixed steps.
        @(posedge clk) reading <= {4{16'h0030}};
        repeat (4) step(2);
        chk(aout[15:0], 16'h0515);
        results();
    end

    // Cuts a hang short well past the expected run length.
    initial
    begin
        #20000;
        error_cnt = error_cnt + 1;
        results();
    end
endmodule : cal_mode_change_sequencer_tb_top

`default_nettype wire
